// file: inc/diag_flags_pkg.sv
// Package with register map, field positions and carrier types for the diagnostic flag block.
package diag_flags_pkg;

  // Register byte offsets on the APB side.
  localparam logic [7:0] OFF_ALARM_FIRST = 8'h00;
  localparam logic [7:0] OFF_ALARM_SECOND = 8'h04;
  localparam logic [7:0] OFF_WARN_FIRST = 8'h08;
  localparam logic [7:0] OFF_WARN_SECOND = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CONTROL = 8'h14;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h18;
  localparam logic [7:0] OFF_THRESH_BASE = 8'h40;

  // Channel numbering, also the threshold index base (four thresholds each).
  localparam int CH_TEMP = 0;
  localparam int CH_VOLT = 1;
  localparam int CH_BIAS = 2;
  localparam int CH_TXPOW = 3;
  localparam int CH_RXPOW = 4;
  localparam int NUM_CH = 5;
  localparam int NUM_THR = 20;

  // Threshold kind within a channel group.
  localparam int THR_ALARM_UPPER = 0;
  localparam int THR_ALARM_LOWER = 1;
  localparam int THR_WARN_UPPER = 2;
  localparam int THR_WARN_LOWER = 3;

  // Control register bit positions.
  localparam int CTL_WARM_RESET = 0;
  localparam int CTL_DRV_LOS = 1;
  localparam int CTL_DRV_RATE = 2;
  localparam int CTL_DRV_FAULT = 3;

  // Pin status bit positions.
  localparam int PIN_FAULT = 0;
  localparam int PIN_LOS = 1;
  localparam int PIN_RATE = 2;
  localparam int PIN_TXDIS = 3;

  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [15:0] THR_RESET = 16'h0000;

  // One averaged measurement result, presented as a one-cycle strobe.
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [15:0] value;
  } meas_t;

  // Open-drain pin carrier: level seen on the pin and our pull-down enable.
  typedef struct packed {
    logic level;
    logic oe;
  } od_pin_t;

endpackage : diag_flags_pkg

// file: logic/diag_alarm_warning_flags.sv
// Diagnostic alarm and warning flag latches with an APB register slave.
//
// Functional notes
// - Twenty conditions; temperature and supply limits set bits 7..4 of first registers.
// - Alarm-limit crossings set flags only in the two alarm registers.
// - Warning-limit crossings set flags only in the two warning registers.
// - Bias above upper sets bit 3, below lower sets bit 2.
// - Transmit power above upper sets bit 1, below lower bit 0.
// - Receive power above upper sets second register bit 7, below bit 6.
// - A true condition sets its flag; no host mask can block it.
// - Flags stay until their register is read, power cycles, or transmit-disable falls.
// - While transmit-disable is high, measurement and flagging continue unchanged.
// - Falling transmit-disable clears all four alarm and warning registers.
// - Fault, loss and rate status bits report the real pin level.
// - Internal fault, loss and rate drivers only pull low or release.
// - Warm reset releases fault and loss and restores all power-on defaults.
// - Warm reset discards a conversion in progress without updating any register.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module diag_alarm_warning_flags #(
  parameter int MEAS_W = 16 // Width of an averaged measurement.
) (
  input wire logic ref_clk, // 100 MHz clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire diag_flags_pkg::meas_t meas, // Averaged measurement strobe.
  input wire logic conv_busy, // A conversion is under way in the converter.
  output logic conv_abort, // One-cycle pulse that stops the converter.
  input wire logic transmit_disable_input, // Transmit-disable pin level.
  input wire logic transmit_fault_out_i, // Level seen on the fault pin.
  output logic transmit_fault_out_o, // Fault pin drive value, always low.
  output logic transmit_fault_out_oe, // Fault pin pull-down enable.
  input wire logic receive_loss_of_signal_i, // Level seen on the loss pin.
  output logic receive_loss_of_signal_o, // Loss pin drive value, always low.
  output logic receive_loss_of_signal_oe, // Loss pin pull-down enable.
  input wire logic rate_select_i, // Level seen on the rate pin.
  output logic rate_select_o, // Rate pin drive value, always low.
  output logic rate_select_oe, // Rate pin pull-down enable.
  output logic irq // Level interrupt, high while an unmasked flag is set.
);

  // Flag registers and software state.
  logic [7:0] alarm_first_r;
  logic [7:0] alarm_second_r;
  logic [7:0] warn_first_r;
  logic [7:0] warn_second_r;
  logic [7:0] alarm_first_nxt;
  logic [7:0] alarm_second_nxt;
  logic [7:0] warn_first_nxt;
  logic [7:0] warn_second_nxt;
  logic [31:0] mask_r;
  logic [3:0] ctl_r;
  logic [MEAS_W-1:0] thr_r [diag_flags_pkg::NUM_THR];
  logic txdis_d_r;
  logic warm_r;

  // Upper-limit test, strict.
  function automatic logic above(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] t);
    above = v > t;
  endfunction : above

  // Lower-limit test, strict.
  function automatic logic below(input logic [MEAS_W-1:0] v, input logic [MEAS_W-1:0] t);
    below = v < t;
  endfunction : below

  // APB decode; an access completes in its first access cycle.
  wire access = psel && penable;
  wire wr_en = access && pwrite;
  wire rd_en = access && !pwrite;
  wire [7:0] a = paddr;
  wire hit_af = a == diag_flags_pkg::OFF_ALARM_FIRST;
  wire hit_as = a == diag_flags_pkg::OFF_ALARM_SECOND;
  wire hit_wf = a == diag_flags_pkg::OFF_WARN_FIRST;
  wire hit_ws = a == diag_flags_pkg::OFF_WARN_SECOND;
  wire hit_mask = a == diag_flags_pkg::OFF_IRQ_MASK;
  wire hit_ctl = a == diag_flags_pkg::OFF_CONTROL;
  wire hit_pin = a == diag_flags_pkg::OFF_PIN_STATUS;
  wire [7:0] thr_off = a - diag_flags_pkg::OFF_THRESH_BASE;
  wire hit_thr = (a >= diag_flags_pkg::OFF_THRESH_BASE) && (thr_off[1:0] == 2'b00)
      && (thr_off[7:2] < 6'(diag_flags_pkg::NUM_THR));
  wire [4:0] thr_idx = thr_off[6:2];
  wire mapped = hit_af || hit_as || hit_wf || hit_ws || hit_mask || hit_ctl || hit_pin
      || hit_thr;

  // Status reads return the actual pin levels, whoever drives them.
  wire [3:0] pin_status = {transmit_disable_input, rate_select_i, receive_loss_of_signal_i,
      transmit_fault_out_i};

  // Read mux.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_af) rd_mux[7:0] = alarm_first_r;
    if (hit_as) rd_mux[7:0] = alarm_second_r;
    if (hit_wf) rd_mux[7:0] = warn_first_r;
    if (hit_ws) rd_mux[7:0] = warn_second_r;
    if (hit_mask) rd_mux = mask_r;
    if (hit_ctl) rd_mux[3:0] = ctl_r;
    if (hit_pin) rd_mux[3:0] = pin_status;
    if (hit_thr) rd_mux[MEAS_W-1:0] = thr_r[thr_idx];
  end

  // Threshold selection for the incoming channel.
  wire [4:0] base = {meas.channel[2:0], 2'b00};
  wire [MEAS_W-1:0] t_au = thr_r[base + 5'(diag_flags_pkg::THR_ALARM_UPPER)];
  wire [MEAS_W-1:0] t_al = thr_r[base + 5'(diag_flags_pkg::THR_ALARM_LOWER)];
  wire [MEAS_W-1:0] t_wu = thr_r[base + 5'(diag_flags_pkg::THR_WARN_UPPER)];
  wire [MEAS_W-1:0] t_wl = thr_r[base + 5'(diag_flags_pkg::THR_WARN_LOWER)];
  // A warm reset in flight drops the result and any strobe in the same cycle.
  wire take = meas.valid && (meas.channel < 3'(diag_flags_pkg::NUM_CH)) && !warm_r;
  wire ev_au = take && above(meas.value, t_au);
  wire ev_al = take && below(meas.value, t_al);
  wire ev_wu = take && above(meas.value, t_wu);
  wire ev_wl = take && below(meas.value, t_wl);

  // Event vectors placed at the bit pair of their channel; alarm and warning kept apart.
  logic [7:0] set_af;
  logic [7:0] set_as;
  logic [7:0] set_wf;
  logic [7:0] set_ws;
  always_comb begin
    set_af = 8'h00;
    set_as = 8'h00;
    set_wf = 8'h00;
    set_ws = 8'h00;
    unique case (meas.channel)
      3'd0: begin
        set_af[7:6] = {ev_au, ev_al};
        set_wf[7:6] = {ev_wu, ev_wl};
      end
      3'd1: begin
        set_af[5:4] = {ev_au, ev_al};
        set_wf[5:4] = {ev_wu, ev_wl};
      end
      3'd2: begin
        set_af[3:2] = {ev_au, ev_al};
        set_wf[3:2] = {ev_wu, ev_wl};
      end
      3'd3: begin
        set_af[1:0] = {ev_au, ev_al};
        set_wf[1:0] = {ev_wu, ev_wl};
      end
      3'd4: begin
        set_as[7:6] = {ev_au, ev_al};
        set_ws[7:6] = {ev_wu, ev_wl};
      end
      default: ;
    endcase
  end

  // Transmit-disable release clears all four flag registers; flagging is not gated by its level.
  wire txdis_fall = txdis_d_r && !transmit_disable_input;

  // Sticky flags: read clears only the addressed register, and a new set wins.
  assign alarm_first_nxt = ((rd_en && hit_af) || txdis_fall ? 8'h00 : alarm_first_r)
      | set_af;
  assign alarm_second_nxt = ((rd_en && hit_as) || txdis_fall ? 8'h00 : alarm_second_r)
      | set_as;
  assign warn_first_nxt = ((rd_en && hit_wf) || txdis_fall ? 8'h00 : warn_first_r)
      | set_wf;
  assign warn_second_nxt = ((rd_en && hit_ws) || txdis_fall ? 8'h00 : warn_second_r)
      | set_ws;

  // Interrupt uses the mask only; the flags themselves are never masked.
  wire [31:0] flat = {alarm_first_r, alarm_second_r, warn_first_r, warn_second_r};
  wire irq_nxt = |(flat & mask_r);

  // Flag registers; warm reset behaves as power-on.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_first_r <= diag_flags_pkg::STATUS_RESET;
      alarm_second_r <= diag_flags_pkg::STATUS_RESET;
      warn_first_r <= diag_flags_pkg::STATUS_RESET;
      warn_second_r <= diag_flags_pkg::STATUS_RESET;
    end else if (warm_r) begin
      alarm_first_r <= diag_flags_pkg::STATUS_RESET;
      alarm_second_r <= diag_flags_pkg::STATUS_RESET;
      warn_first_r <= diag_flags_pkg::STATUS_RESET;
      warn_second_r <= diag_flags_pkg::STATUS_RESET;
    end else begin
      alarm_first_r <= alarm_first_nxt;
      alarm_second_r <= alarm_second_nxt;
      warn_first_r <= warn_first_nxt;
      warn_second_r <= warn_second_nxt;
    end
  end

  // Warm-reset request: written bit becomes a one-cycle internal reset, self-clearing.
  wire warm_req = wr_en && hit_ctl && pstrb[0] && pwdata[diag_flags_pkg::CTL_WARM_RESET];

  // Software registers: mask, drive controls, thresholds.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= diag_flags_pkg::MASK_RESET;
      ctl_r <= 4'h0;
      warm_r <= 1'b0;
      txdis_d_r <= 1'b0;
      for (int i = 0; i < diag_flags_pkg::NUM_THR; i++) thr_r[i] <= MEAS_W'(diag_flags_pkg::THR_RESET);
    end else begin
      txdis_d_r <= transmit_disable_input;
      warm_r <= warm_req;
      if (warm_r) begin
        mask_r <= diag_flags_pkg::MASK_RESET;
        ctl_r <= 4'h0;
        for (int i = 0; i < diag_flags_pkg::NUM_THR; i++) thr_r[i] <= MEAS_W'(diag_flags_pkg::THR_RESET);
      end else if (wr_en) begin
        for (int b = 0; b < 4; b++) begin
          if (hit_mask && pstrb[b]) mask_r[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
        if (hit_ctl && pstrb[0]) ctl_r <= {pwdata[3:1], 1'b0};
        for (int b = 0; b < MEAS_W / 8; b++) begin
          if (hit_thr && pstrb[b]) thr_r[thr_idx][b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
    end
  end

  // Bus answer and pin drivers, all registered.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
      conv_abort <= 1'b0;
      transmit_fault_out_oe <= 1'b0;
      receive_loss_of_signal_oe <= 1'b0;
      rate_select_oe <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
      irq <= warm_r ? 1'b0 : irq_nxt;
      conv_abort <= warm_req && conv_busy;
      // Pull-down only: fault and loss released at warm reset.
      transmit_fault_out_oe <= !warm_req && ctl_r[diag_flags_pkg::CTL_DRV_FAULT];
      receive_loss_of_signal_oe <= !warm_req && ctl_r[diag_flags_pkg::CTL_DRV_LOS];
      rate_select_oe <= !warm_req && ctl_r[diag_flags_pkg::CTL_DRV_RATE];
    end
  end

  // Drive value is a constant low, so the pins are never pushed high.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transmit_fault_out_o <= 1'b0;
      receive_loss_of_signal_o <= 1'b0;
      rate_select_o <= 1'b0;
    end else begin
      transmit_fault_out_o <= 1'b0;
      receive_loss_of_signal_o <= 1'b0;
      rate_select_o <= 1'b0;
    end
  end

endmodule : diag_alarm_warning_flags

// file: test/diag_flags_properties.sv
// Port-level property checker for the diagnostic flag block.
module diag_flags_properties (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Strobes.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic conv_busy, // Converter busy.
  input wire logic conv_abort, // Converter stop.
  input wire logic transmit_fault_out_i, // Fault pin level.
  input wire logic transmit_fault_out_o, // Fault drive.
  input wire logic transmit_fault_out_oe, // Fault enable.
  input wire logic receive_loss_of_signal_oe, // Loss enable.
  input wire logic rate_select_oe // Rate enable.
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // A taken control write with the warm reset bit set.
  wire logic warm_wr = psel && penable && pwrite && paddr == diag_flags_pkg::OFF_CONTROL
    && pwdata[0] && pstrb[0];

  access_ready_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("No ready in the access cycle.");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("Ready outside an access cycle.");
  unmapped_err_a: assert property (pready && paddr == 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused.");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data outside ready.");
  od_low_a: assert property (transmit_fault_out_oe |-> !transmit_fault_out_o)
    else $error("Fault pin driven high.");
  pin_level_a: assert property (pready && !pwrite && paddr == diag_flags_pkg::OFF_PIN_STATUS
    && $stable(transmit_fault_out_i) |-> prdata[0] == transmit_fault_out_i)
    else $error("Fault status not pin level.");
  abort_once_a: assert property (conv_abort |=> !conv_abort)
    else $error("Abort longer than one cycle.");
  abort_cause_a: assert property (warm_wr && conv_busy |=> conv_abort)
    else $error("Warm reset did not stop conversion.");
  warm_release_a: assert property (warm_wr |=> !transmit_fault_out_oe
    && !receive_loss_of_signal_oe && !rate_select_oe)
    else $error("Warm reset left a pin pulled.");
endmodule : diag_flags_properties

bind diag_alarm_warning_flags diag_flags_properties chk (.ref_clk(ref_clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_busy(conv_busy), .conv_abort(conv_abort),
  .transmit_fault_out_i(transmit_fault_out_i), .transmit_fault_out_o(transmit_fault_out_o),
  .transmit_fault_out_oe(transmit_fault_out_oe),
  .receive_loss_of_signal_oe(receive_loss_of_signal_oe), .rate_select_oe(rate_select_oe));

// file: test/conv_model.sv
// Converter stand-in that delivers one averaged result per request.
module conv_model (
  input wire logic ref_clk, // Clock.
  input wire logic req, // Start one conversion.
  input wire logic [2:0] ch, // Channel.
  input wire logic [15:0] val, // Result value.
  input wire logic hold, // Stretch a running conversion.
  input wire logic abort, // Stop from the block.
  output diag_flags_pkg::meas_t meas, // Result strobe.
  output logic busy // Conversion under way.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stopped conversion never delivers, so no stale result can sneak in.
  initial begin
    busy = 1'b0;
    meas = '0;
  end
  always @(posedge ref_clk) begin
    meas <= '0;
    if (abort) begin
      busy <= 1'b0;
    end else if (req || (hold && busy)) begin
      busy <= 1'b1;
    end else if (busy) begin
      busy <= 1'b0;
      meas <= '{1'b1, ch, val};
    end
  end
endmodule : conv_model

// file: test/testbench.sv
// Self-checking bench for the diagnostic alarm and warning flag block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_abort, irq, busy, req = 0, hold = 0, txdis = 0, mk = 0;
  logic ext_f = 1, ext_l = 1, ext_r = 1, f_oe, l_oe, r_oe;
  logic [2:0] ch_s = 0;
  logic [15:0] val_s = 0;
  diag_flags_pkg::meas_t meas;
  logic [31:0] rd;
  logic er;
  int thr[20];
  int st[4];
  int errors = 0;
  int tests_run = 0;
  int vals[8] = '{201, 200, 151, 150, 100, 99, 50, 49};
  // Open-drain pins idle high through pull-ups unless someone pulls low.
  wire logic f_lvl = ext_f & ~f_oe;
  wire logic l_lvl = ext_l & ~l_oe;
  wire logic r_lvl = ext_r & ~r_oe;
  always #5 ref_clk = ~ref_clk;
  diag_alarm_warning_flags uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .conv_busy(busy), .conv_abort(conv_abort),
    .transmit_disable_input(txdis), .transmit_fault_out_i(f_lvl), .transmit_fault_out_o(),
    .transmit_fault_out_oe(f_oe), .receive_loss_of_signal_i(l_lvl), .receive_loss_of_signal_o(),
    .receive_loss_of_signal_oe(l_oe), .rate_select_i(r_lvl), .rate_select_o(),
    .rate_select_oe(r_oe), .irq(irq));
  conv_model cm (.ref_clk(ref_clk), .req(req), .ch(ch_s), .val(val_s), .hold(hold),
    .abort(conv_abort), .meas(meas), .busy(busy));
  task finish_test;
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One APB transfer; the request holds until the rising edge that sees ready high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // Deliver a result, then predict which flags it must set.
  task send(input int c, input int v);
    int b;
    int s;
    ch_s <= c[2:0];
    val_s <= v[15:0];
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    b = (c == 4) ? 7 : 7 - 2 * c;
    s = (c == 4) ? 1 : 0;
    if (v > thr[4 * c]) st[s] |= 1 << b;
    if (v < thr[4 * c + 1]) st[s] |= 1 << (b - 1);
    if (v > thr[4 * c + 2]) st[s + 2] |= 1 << b;
    if (v < thr[4 * c + 3]) st[s + 2] |= 1 << (b - 1);
  endtask : send
  // Read all four status words; each read empties only its own word.
  task readall;
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      check("irq", irq, mk && st[0] != 0);
      @(posedge ref_clk);
      apb(1'b0, 8'(4 * i), 32'h0);
      check("status", rd, st[i]);
      st[i] = 0;
    end
  endtask : readall
  // Main sequence.
  initial begin
    void'($urandom(32'h359d));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    readall();
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    for (int i = 0; i < 20; i++) begin
      thr[i] = (i % 4 == 0) ? 200 : (i % 4 == 1) ? 50 : (i % 4 == 2) ? 150 : 100;
      apb(1'b1, 8'(8'h40 + 4 * i), thr[i]);
    end
    apb(1'b1, diag_flags_pkg::OFF_IRQ_MASK, 32'hff00_0000);
    mk = 1'b1;
    for (int c = 0; c < 5; c++) begin
      foreach (vals[k]) begin
        send(c, vals[k]);
        readall();
      end
    end
    repeat (12) begin
      send($urandom_range(0, 4), $urandom_range(0, 300));
      send($urandom_range(0, 4), $urandom_range(0, 300));
      readall();
    end
    // Flags raised under transmit-disable vanish when it is released.
    send(0, 201);
    txdis <= 1'b1;
    send(2, 0);
    apb(1'b0, diag_flags_pkg::OFF_WARN_FIRST, 32'h0);
    check("busy flags", rd, st[2]);
    st[2] = 0;
    txdis <= 1'b0;
    repeat (3) @(posedge ref_clk);
    st = '{0, 0, 0, 0};
    readall();
    ext_f <= 1'($urandom);
    ext_l <= 1'($urandom);
    apb(1'b1, diag_flags_pkg::OFF_CONTROL, 32'h8);
    apb(1'b0, diag_flags_pkg::OFF_PIN_STATUS, 32'h0);
    check("pins", rd[3:0], {txdis, ext_r, ext_l, 1'b0});
    hold <= 1'b1;
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    apb(1'b1, diag_flags_pkg::OFF_CONTROL, 32'h1);
    hold <= 1'b0;
    check("fault oe", f_oe, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check("threshold", rd, 32'h0);
    thr = '{default: 0};
    mk = 1'b0;
    send(0, 5);
    readall();
    finish_test();
  end
endmodule : testbench
